// ===== hw/ascp_pkg.sv
/*
  Shared constants for the converter serial control port: timing counts,
  frame layout, device register map and the host controller's own map.
  Assumes a 50 MHz reference clock on both ends.
*/
package ascp_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_NS          = 20;
  localparam int CONV_NS         = 600;
  localparam int CONV_CYC        = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_GAP_NS     = 2000;
  localparam int INIT_GAP_CYC    = (INIT_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_PULSES     = 66;
  localparam int QUIET_NS        = 1000;
  localparam int QUIET_CYC       = (QUIET_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNV_PW_NS       = 200;
  localparam int CNV_PW_CYC      = (CNV_PW_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_MARGIN_CYC = 4;
  localparam int SCLK_HALF_CYC   = 8;
  // ==========================================================
  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int ADDR_MSB   = 15;
  localparam int ADDR_LSB   = 11;
  localparam int WR_BIT     = 10;
  // ==========================================================
  // Device threshold registers
  localparam int         FIELD_W    = 9;
  localparam logic [8:0] LOWER_RST  = 9'h000;
  localparam logic [8:0] UPPER_RST  = 9'h1FF;
  localparam logic [8:0] HYST_RST   = 9'h1FF;
  localparam logic [2:0] LOWER_PAD  = 3'h0;
  localparam logic [2:0] UPPER_PAD  = 3'h7;
  localparam logic [2:0] HYST_PAD   = 3'h0;
  localparam logic [4:0] RESULT_ADR = 5'h00;
  localparam int         CH_BASE    = 4;
  localparam int         CH_STRIDE  = 3;
  localparam int         OFS_LOWER  = 0;
  localparam int         OFS_UPPER  = 1;
  localparam int         OFS_HYST   = 2;
  // ==========================================================
  // Host controller registers (AHB-Lite byte offsets)
  localparam logic [3:0] HOST_CMD_OFS  = 4'h0;
  localparam logic [3:0] HOST_STAT_OFS = 4'h4;
  localparam logic [3:0] HOST_RX_OFS   = 4'h8;
  localparam int         CMD_CONV_BIT  = 16;
  localparam int         CMD_INIT_BIT  = 17;

  // Register address of field k of channel c
  function automatic logic [4:0] ascp_reg_adr(input int c, input int k);
    ascp_reg_adr = 5'(CH_BASE + CH_STRIDE * c + k);
  endfunction
endpackage

// ===== hw/ascp_link_if.sv
/*
  Serial link between host controller and converter device.
  Assumes a pull-up on the data line: a released line reads high.
*/
`timescale 1ns/1ns
interface ascp_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic convert_start_n;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  // Released data line shows its pull-up level, so the host never reads a stale bit
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev  (input cs_n, sclk, sdi, convert_start_n, output sdo, sdo_oe);
  modport host (output cs_n, sclk, sdi, convert_start_n, input sdo_line);
endinterface

// ===== hw/ascp_sync.sv
/*
  Two flip-flop level synchroniser, one per bit.
  Assumes inputs are quasi-static relative to the clock.
*/
`timescale 1ns/1ns
module ascp_sync
#(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)(
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;

  // ==========================================================
  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      meta_q <= RST_VAL;
      q_o    <= RST_VAL;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// ===== hw/ascp_device.sv
/*
  Converter device end: threshold registers, serial command port,
  conversion timing and limit alerts. Analog sampling is replaced by
  sample_data_i / sample_chan_i, which must be stable around convert start.
*/
// What this block does
// - lower threshold is field then 000
// - upper threshold is field then 111
// - hysteresis N is field then 000
// - fields reset 000/1FF/1FF, upper bits read zero
// - data out driven only while selected
// - accept either clock idle level
// - clock edges ignored while deselected
// - convert start falling edge: 600 ns conversion
// - host releases start, waits before reading
// - 16 bits MSB first, first at select
// - last bit from 15th fall, holds
// - host deselects after 16th fall, waits 1us
// - write frame: address, bit10 set, data
// - read frame: address, bit10 clear
// - read data returned in next frame
// - conversion result overrides pending read
// - 66 spaced start pulses initialise device
// - host rewrites all registers after init
// - host waits 50 ms for reference; bench does not wait
// - alert when result leaves threshold window
// - alert self clears unless sticky mode
`timescale 1ns/1ns
module ascp_device
  import ascp_pkg::*;
#(
  parameter int NUM_CH = 4
)(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  ascp_link_if.dev               link,
  input  wire logic [11:0]       sample_data_i,
  input  wire logic [2:0]        sample_chan_i,
  input  wire logic              sticky_alert_mode_i,
  output logic                   alert_busy_out_pin_o,
  output logic [2*NUM_CH-1:0]    alert_status_o,
  output logic                   conv_busy_o,
  output logic                   init_done_o
);
  localparam int CW = $clog2(CONV_CYC + 1);
  localparam int GW = $clog2(INIT_GAP_CYC + 1);

  logic [3:0]  sync_s;
  logic        cs_s, sclk_s, sdi_s, cnv_s;
  logic        cs_p_q, sclk_p_q, cnv_p_q;
  logic        cs_fall, cs_rise, sclk_rise, sclk_fall, cnv_fall;
  logic [4:0]  rise_cnt_q;
  logic [15:0] rx_q, tx_q, rd_data_q, rd_word, result_word;
  logic        sdo_q, sdo_oe_q, read_pend_q, frame_done, wr_cmd;
  logic [4:0]  cmd_adr;
  logic [CW-1:0] conv_cnt_q;
  logic [11:0] samp_q, res_q;
  logic [2:0]  samp_chan_q, res_chan_q;
  logic        conv_done, alert_any;
  logic [6:0]  pulse_cnt_q;
  logic [GW-1:0] gap_cnt_q;
  logic        init_rst;
  logic [8:0]  lo_q [NUM_CH];
  logic [8:0]  hi_q [NUM_CH];
  logic [8:0]  hy_q [NUM_CH];
  logic        hi_al_q [NUM_CH];
  logic        lo_al_q [NUM_CH];

  // ==========================================================
  // Link inputs cross into the reference clock domain
  ascp_sync #(
    .WIDTH   (4),
    .RST_VAL (4'hC)
  ) u_sync (
    .clk_i   (ref_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({link.convert_start_n, link.cs_n, link.sclk, link.sdi}),
    .q_o     (sync_s)
  );
  assign cnv_s  = sync_s[3];
  assign cs_s   = sync_s[2];
  assign sclk_s = sync_s[1];
  assign sdi_s  = sync_s[0];

  // Previous values for edge detection
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      cs_p_q   <= 1'b1;
      sclk_p_q <= 1'b0;
      cnv_p_q  <= 1'b1;
    end
    else
    begin
      cs_p_q   <= cs_s;
      sclk_p_q <= sclk_s;
      cnv_p_q  <= cnv_s;
    end
  end

  assign cs_fall   = cs_p_q & ~cs_s;
  assign cs_rise   = ~cs_p_q & cs_s;
  assign sclk_rise = ~sclk_p_q & sclk_s & ~cs_s;
  assign sclk_fall = sclk_p_q & ~sclk_s & ~cs_s;
  assign cnv_fall  = cnv_p_q & ~cnv_s;

  // ==========================================================
  // Receive side: sample on each rising edge, at most 16 bits
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      rise_cnt_q <= 5'h00;
      rx_q       <= 16'h0000;
    end
    else if (cs_fall)
      rise_cnt_q <= 5'h00;
    else if (sclk_rise && rise_cnt_q < 5'(FRAME_BITS))
    begin
      rise_cnt_q <= rise_cnt_q + 5'h01;
      rx_q       <= {rx_q[14:0], sdi_s};
    end
  end

  // Only complete 16-bit frames carry a command
  assign frame_done = cs_rise && rise_cnt_q == 5'(FRAME_BITS);
  assign cmd_adr    = rx_q[ADDR_MSB:ADDR_LSB];
  assign wr_cmd     = frame_done && rx_q[WR_BIT];

  // ==========================================================
  // Transmit side. A fall before any rise (idle-high clock) is the
  // launch edge of the MSB already out, so it must not shift.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      tx_q     <= 16'h0000;
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
    end
    else if (cs_fall)
    begin
      tx_q     <= read_pend_q ? rd_data_q : result_word;
      sdo_q    <= read_pend_q ? rd_data_q[15] : result_word[15];
      sdo_oe_q <= 1'b1;
    end
    else if (cs_rise)
      sdo_oe_q <= 1'b0;
    else if (sclk_fall && rise_cnt_q != 5'h00 && rise_cnt_q < 5'(FRAME_BITS))
    begin
      tx_q  <= {tx_q[14:0], 1'b0};
      sdo_q <= tx_q[14];
    end
  end
  assign link.sdo    = sdo_q;
  assign link.sdo_oe = sdo_oe_q;

  // ==========================================================
  // Register readback word, reserved bits zero
  always_comb
  begin
    rd_word = 16'h0000;
    if (cmd_adr == RESULT_ADR)
      rd_word = result_word;
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (cmd_adr == ascp_reg_adr(c, OFS_LOWER))
        rd_word = {7'h00, lo_q[c]};
      if (cmd_adr == ascp_reg_adr(c, OFS_UPPER))
        rd_word = {7'h00, hi_q[c]};
      if (cmd_adr == ascp_reg_adr(c, OFS_HYST))
        rd_word = {7'h00, hy_q[c]};
    end
  end

  // Pending read: a conversion in between discards it
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i || init_rst)
    begin
      read_pend_q <= 1'b0;
      rd_data_q   <= 16'h0000;
    end
    else if (conv_done)
      read_pend_q <= 1'b0;
    else if (frame_done)
    begin
      read_pend_q <= ~rx_q[WR_BIT];
      rd_data_q   <= rd_word;
    end
  end

  // ==========================================================
  // Conversion timing; starts during a conversion are ignored
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      conv_busy_o <= 1'b0;
      conv_cnt_q  <= '0;
      samp_q      <= 12'h000;
      samp_chan_q <= 3'h0;
      res_q       <= 12'h000;
      res_chan_q  <= 3'h0;
    end
    else if (cnv_fall && !conv_busy_o)
    begin
      conv_busy_o <= 1'b1;
      conv_cnt_q  <= CW'(CONV_CYC - 1);
      samp_q      <= sample_data_i;
      samp_chan_q <= sample_chan_i;
    end
    else if (conv_done)
    begin
      conv_busy_o <= 1'b0;
      res_q       <= samp_q;
      res_chan_q  <= samp_chan_q;
    end
    else if (conv_busy_o)
      conv_cnt_q <= conv_cnt_q - CW'(1);
  end
  assign conv_done   = conv_busy_o && conv_cnt_q == '0;
  assign result_word = {res_chan_q, alert_busy_out_pin_o, res_q};

  // ==========================================================
  // Pulse-train initialisation: 66 starts, each 2 us after the last.
  // A too-close start restarts the count; any frame aborts it.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      pulse_cnt_q <= 7'h00;
      gap_cnt_q   <= GW'(INIT_GAP_CYC);
      init_done_o <= 1'b0;
    end
    else
    begin
      init_done_o <= init_rst;
      if (cnv_fall)
        gap_cnt_q <= '0;
      else if (gap_cnt_q < GW'(INIT_GAP_CYC))
        gap_cnt_q <= gap_cnt_q + GW'(1);
      if (cs_fall || init_rst)
        pulse_cnt_q <= 7'h00;
      else if (cnv_fall)
        pulse_cnt_q <= (gap_cnt_q >= GW'(INIT_GAP_CYC)) ?
                       pulse_cnt_q + 7'h01 : 7'h01;
    end
  end
  assign init_rst = cnv_fall && gap_cnt_q >= GW'(INIT_GAP_CYC) &&
                    pulse_cnt_q == 7'(INIT_PULSES - 1);

  // ==========================================================
  // Per-channel thresholds and alerts
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    logic [11:0] lo12, hi12, n12;
    logic        hit;

    assign lo12 = {lo_q[c], LOWER_PAD};
    assign hi12 = {hi_q[c], UPPER_PAD};
    assign n12  = {hy_q[c], HYST_PAD};
    assign hit  = conv_done && samp_chan_q == 3'(c);

    // Register writes; only the 9 field bits are stored
    always_ff @(posedge ref_clk_i)
    begin
      if (!rst_b_i || init_rst)
      begin
        lo_q[c] <= LOWER_RST;
        hi_q[c] <= UPPER_RST;
        hy_q[c] <= HYST_RST;
      end
      else if (wr_cmd)
      begin
        if (cmd_adr == ascp_reg_adr(c, OFS_LOWER))
          lo_q[c] <= rx_q[8:0];
        if (cmd_adr == ascp_reg_adr(c, OFS_UPPER))
          hi_q[c] <= rx_q[8:0];
        if (cmd_adr == ascp_reg_adr(c, OFS_HYST))
          hy_q[c] <= rx_q[8:0];
      end
    end

    // Set on leaving the window; 13-bit sums avoid wrap
    always_ff @(posedge ref_clk_i)
    begin
      if (!rst_b_i || init_rst)
      begin
        hi_al_q[c] <= 1'b0;
        lo_al_q[c] <= 1'b0;
      end
      else if (hit)
      begin
        if (samp_q > hi12)
          hi_al_q[c] <= 1'b1;
        else if (!sticky_alert_mode_i &&
                 {1'b0, samp_q} + {1'b0, n12} <= {1'b0, hi12})
          hi_al_q[c] <= 1'b0;
        if (samp_q < lo12)
          lo_al_q[c] <= 1'b1;
        else if (!sticky_alert_mode_i &&
                 {1'b0, samp_q} >= {1'b0, lo12} + {1'b0, n12})
          lo_al_q[c] <= 1'b0;
      end
    end
    assign alert_status_o[2*c]   = hi_al_q[c];
    assign alert_status_o[2*c+1] = lo_al_q[c];
  end

  // Common alert, registered one cycle after the status bits
  assign alert_any = |alert_status_o;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      alert_busy_out_pin_o <= 1'b0;
    else
      alert_busy_out_pin_o <= alert_any;
  end
endmodule

// ===== hw/ascp_host.sv
/*
  Host controller end: AHB-Lite slave with command, status and receive
  registers; drives convert start, chip select and the serial clock.
  Assumes one AHB master, single word transfers, 50 MHz clock.
*/
`timescale 1ns/1ns
module ascp_host
  import ascp_pkg::*;
#(
  parameter int       HALF_CYC = SCLK_HALF_CYC,
  parameter bit       CPOL     = 1'b0
)(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  ascp_link_if.host        link,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o
);
  typedef enum logic [2:0] {H_IDLE, H_CNV_LO, H_CNV_WT, H_FRAME, H_GAP} ascp_hst_t;

  ascp_hst_t   st_q;
  logic        wr_pend_q, busy, cmd_go, sdo_s, rise;
  logic [3:0]  wr_adr_q;
  logic [15:0] tx_q, rx_q, rx_data_q;
  logic        conv_q, init_q, init_done_q;
  logic [6:0]  pulse_cnt_q;
  logic [15:0] wait_q;
  logic [5:0]  edge_cnt_q;

  assign busy = st_q != H_IDLE;
  assign rise = link.sclk == 1'b0;

  // ==========================================================
  // AHB-Lite slave, zero wait states; writes land in the data phase
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      wr_pend_q   <= 1'b0;
      wr_adr_q    <= 4'h0;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      wr_pend_q   <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
      wr_adr_q    <= haddr_i[3:0];
      hrdata_o    <= 32'h0000_0000;
      if (hsel_i && hready_i && htrans_i[1] && !hwrite_i)
      begin
        case (haddr_i[3:0])
          HOST_STAT_OFS: hrdata_o <= {30'h0, init_done_q, busy};
          HOST_RX_OFS:   hrdata_o <= {16'h0000, rx_data_q};
          default:       hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  // Commands while busy are dropped; software polls status first
  assign cmd_go = wr_pend_q && wr_adr_q == HOST_CMD_OFS && !busy;

  // ==========================================================
  // Data line from the device crosses into this domain
  ascp_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) u_sync (
    .clk_i   (ref_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (link.sdo_line),
    .q_o     (sdo_s)
  );

  // ==========================================================
  // Sequencer: start pulse, conversion wait, frame, quiet gap
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      st_q                 <= H_IDLE;
      link.cs_n            <= 1'b1;
      link.sclk            <= CPOL;
      link.sdi             <= 1'b0;
      link.convert_start_n <= 1'b1;
      tx_q                 <= 16'h0000;
      rx_q                 <= 16'h0000;
      rx_data_q            <= 16'h0000;
      conv_q               <= 1'b0;
      init_q               <= 1'b0;
      init_done_q          <= 1'b0;
      pulse_cnt_q          <= 7'h00;
      wait_q               <= 16'h0000;
      edge_cnt_q           <= 6'h00;
    end
    else
    begin
      case (st_q)
        H_IDLE:
          if (cmd_go)
          begin
            tx_q        <= hwdata_i[15:0];
            conv_q      <= hwdata_i[CMD_CONV_BIT];
            init_q      <= hwdata_i[CMD_INIT_BIT];
            pulse_cnt_q <= 7'h00;
            wait_q      <= 16'(CNV_PW_CYC - 1);
            if (hwdata_i[CMD_INIT_BIT])
              init_done_q <= 1'b0;
            if (hwdata_i[CMD_CONV_BIT] || hwdata_i[CMD_INIT_BIT])
            begin
              st_q                 <= H_CNV_LO;
              link.convert_start_n <= 1'b0;
            end
            else
            begin
              st_q       <= H_FRAME;
              link.cs_n  <= 1'b0;
              link.sdi   <= hwdata_i[15];
              wait_q     <= 16'(HALF_CYC - 1);
              edge_cnt_q <= 6'h00;
            end
          end
        H_CNV_LO:
          if (wait_q == 16'h0000)
          begin
            // Start returns high well before the conversion ends
            link.convert_start_n <= 1'b1;
            st_q                 <= H_CNV_WT;
            wait_q <= init_q ? 16'(INIT_GAP_CYC - CNV_PW_CYC) :
                      16'(CONV_CYC + SYNC_MARGIN_CYC);
          end
          else
            wait_q <= wait_q - 16'h0001;
        H_CNV_WT:
          if (wait_q != 16'h0000)
            wait_q <= wait_q - 16'h0001;
          else if (init_q && pulse_cnt_q != 7'(INIT_PULSES - 1))
          begin
            pulse_cnt_q          <= pulse_cnt_q + 7'h01;
            st_q                 <= H_CNV_LO;
            link.convert_start_n <= 1'b0;
            wait_q               <= 16'(CNV_PW_CYC - 1);
          end
          else if (init_q)
          begin
            init_done_q <= 1'b1;
            st_q        <= H_IDLE;
          end
          else
          begin
            st_q       <= H_FRAME;
            link.cs_n  <= 1'b0;
            link.sdi   <= tx_q[15];
            wait_q     <= 16'(HALF_CYC - 1);
            edge_cnt_q <= 6'h00;
          end
        H_FRAME:
          if (wait_q != 16'h0000)
            wait_q <= wait_q - 16'h0001;
          else if (edge_cnt_q == 6'(2 * FRAME_BITS))
          begin
            // Deselect only after the last edge, then keep quiet
            link.cs_n <= 1'b1;
            rx_data_q <= rx_q;
            st_q      <= H_GAP;
            wait_q    <= 16'(QUIET_CYC - 1);
          end
          else
          begin
            link.sclk  <= ~link.sclk;
            edge_cnt_q <= edge_cnt_q + 6'h01;
            wait_q     <= 16'(HALF_CYC - 1);
            if (rise)
              rx_q <= {rx_q[14:0], sdo_s};
            else if (edge_cnt_q != 6'h00)
            begin
              tx_q     <= {tx_q[14:0], 1'b0};
              link.sdi <= tx_q[14];
            end
          end
        H_GAP:
          if (wait_q != 16'h0000)
            wait_q <= wait_q - 16'h0001;
          else
            st_q <= H_IDLE;
        default:
          st_q <= H_IDLE;
      endcase
    end
  end
endmodule

// ===== tb/ascp_link_monitor.sv
/*
  Assertions on the serial link wires between host and device.
  Assumes host clock idle low and the default half period.
*/
`timescale 1ns/1ns
module ascp_link_monitor
  import ascp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic convert_start_n,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic       sclk_q;
  logic [4:0] rise_cnt_q;
  logic       cnv_q;
  logic [5:0] since_cnv_q;

  // Count clock rises in a frame; deselect clears it
  always_ff @(posedge ref_clk_i)
  begin
    sclk_q <= sclk;
    if (cs_n)
      rise_cnt_q <= 5'h00;
    else if (sclk && !sclk_q)
      rise_cnt_q <= rise_cnt_q + 5'h01;
  end

  // Cycles since the last convert start fall, saturating
  always_ff @(posedge ref_clk_i)
  begin
    cnv_q <= convert_start_n;
    if (!rst_b_i)
      since_cnv_q <= 6'h3F;
    else if (cnv_q && !convert_start_n)
      since_cnv_q <= 6'h00;
    else if (since_cnv_q != 6'h3F)
      since_cnv_q <= since_cnv_q + 6'h01;
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========
  // Assertions
  oe_off_a: assert property (cs_n [*4] |-> !sdo_oe)
    else $error("data out driven while deselected");
  oe_on_a: assert property ($fell(cs_n) |-> ##[1:6] sdo_oe)
    else $error("data out not driven after select");
  idle_low_a: assert property (cs_n |-> !sclk)
    else $error("serial clock not idle");
  start_pw_a: assert property ($fell(convert_start_n) |-> ##[1:29] convert_start_n)
    else $error("convert start held too long");
  read_wait_a: assert property ($fell(cs_n) |-> since_cnv_q >= 6'(CONV_CYC))
    else $error("frame began during conversion");
  sdo_hold_a: assert property ($rose(sclk) && !cs_n |-> $stable(sdo))
    else $error("data out moved at clock rise");
  last_bit_a: assert property (rise_cnt_q == 5'h10 && !cs_n |-> $stable(sdo))
    else $error("last bit not held");
  frame_len_a: assert property ($rose(cs_n) |-> rise_cnt_q == 5'h10)
    else $error("frame not 16 clocks");
  gap_a: assert property ($rose(cs_n) |-> (cs_n && convert_start_n) [*8])
    else $error("no quiet gap after frame");
  sdi_hold_a: assert property ($rose(sclk) && !cs_n |-> $stable(sdi))
    else $error("data in moved at clock rise");
  cover property ($rose(cs_n) && rise_cnt_q == 5'h10);
  cover property ($fell(convert_start_n));
  cover property (sdo_oe && sdo);
endmodule

// ===== tb/test_adc_serial_control_port.sv
/*
  Bench: host and device joined by the link, host driven over AHB-Lite.
  Assumes a 50 MHz clock and the package register map.
*/
`timescale 1ns/1ns
module test_adc_serial_control_port
  import ascp_pkg::*;
;
  logic        clk    = 1'b0;
  logic        rst_b  = 1'b0;
  logic        hsel   = 1'b0;
  logic        hwrite = 1'b0;
  logic        sticky = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr  = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [11:0] smp    = 12'h000;
  logic [2:0]  chn    = 3'h0;
  wire  [31:0] hrdata;
  wire         hready;
  wire         pin;
  wire  [7:0]  ast;
  wire         cbusy;
  wire         idone;
  int          n_busy = 0;
  int          n_init = 0;
  int          miscompares = 0;
  int          total_checks = 0;
  int          rg[4][3];
  bit          ah[4];
  bit          al[4];

  // 50 MHz clock
  always #10 clk = ~clk;

  ascp_link_if lnk ();
  ascp_link_monitor u_ascp_link_monitor (.ref_clk_i(clk), .rst_b_i(rst_b), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .sdi(lnk.sdi), .convert_start_n(lnk.convert_start_n), .sdo(lnk.sdo),
    .sdo_oe(lnk.sdo_oe));
  ascp_device #(.NUM_CH(4)) u_ascp_device (.ref_clk_i(clk), .rst_b_i(rst_b), .link(lnk),
    .sample_data_i(smp), .sample_chan_i(chn), .sticky_alert_mode_i(sticky),
    .alert_busy_out_pin_o(pin), .alert_status_o(ast), .conv_busy_o(cbusy),
    .init_done_o(idone));
  ascp_host u_ascp_host (.ref_clk_i(clk), .rst_b_i(rst_b), .link(lnk), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o());

  // Busy cycles and init pulses, sampled where they are settled
  always @(negedge clk)
  begin
    if (cbusy === 1'b1)
      n_busy++;
    if (idone === 1'b1)
      n_init++;
  end

  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One single word transfer; waits on hready, no fixed latency assumed
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  // Send one frame, wait until idle, fetch the received word
  task automatic frame(input logic [15:0] w, input logic cv, output logic [15:0] rx);
    logic [31:0] r;
    ahb(1'b1, 32'(HOST_CMD_OFS), {15'h0000, cv, w}, r);
    r = 32'h1;
    while (r[0] !== 1'b0)
      ahb(1'b0, 32'(HOST_STAT_OFS), 32'h0, r);
    ahb(1'b0, 32'(HOST_RX_OFS), 32'h0, r);
    rx = r[15:0];
  endtask

  // Read request with junk low bits, then an all-zero frame (a read of the result register)
  task automatic rd(input int c, input int k, output logic [15:0] x);
    frame({5'(4 + 3 * c + k), 1'b0, 10'($urandom)}, 1'b0, x);
    frame(16'h0000, 1'b0, x);
  endtask

  // Alert model; thresholds widened as the device does
  task automatic model_conv(input int c, input int r);
    int l12 = rg[c][0] * 8;
    int u12 = rg[c][1] * 8 + 7;
    int n   = rg[c][2] * 8;
    ah[c] = (r > u12) | (ah[c] & (sticky | (r + n > u12)));
    al[c] = (r < l12) | (al[c] & (sticky | (r < l12 + n)));
  endtask

  // ==========
  // Main sequence
  initial
  begin
    logic [15:0] x;
    logic [31:0] r;
    logic [7:0]  ea;
    int          c;
    int          k;
    int          v;
    void'($urandom(31));
    foreach (rg[i]) rg[i] = '{0, 511, 511};
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    for (c = 0; c < 4; c++)
      for (k = 0; k < 3; k++)
      begin
        rd(c, k, x);
        chk(32'(x), 32'(rg[c][k]));
      end
    // Random writes, a pending read cancelled by a conversion, readback
    repeat (12)
    begin
      c = $urandom % 4;
      for (k = 0; k < 3; k++)
      begin
        v = $urandom % 1024;
        frame({5'(4 + 3 * c + k), 1'b1, 10'(v)}, 1'b0, x);
        rg[c][k] = v % 512;
      end
      k = $urandom % 3;
      frame({5'(4 + 3 * c + k), 1'b0, 10'h3FF}, 1'b0, x);
      smp <= 12'($urandom);
      chn <= 3'(c);
      sticky <= ($urandom % 4 == 0);
      frame(16'h0000, 1'b1, x);
      model_conv(c, int'(smp));
      for (v = 0; v < 4; v++)
        ea[2*v +: 2] = {al[v], ah[v]};
      chk(32'(x), {16'h0000, 3'(c), |ea, smp});
      chk(32'(ast), 32'(ea));
      chk(32'(pin), 32'(|ea));
      rd(c, k, x);
      chk(32'(x), 32'(rg[c][k]));
    end
    // Start pulse train, then registers back at reset values
    ahb(1'b1, 32'(HOST_CMD_OFS), 32'h1 << CMD_INIT_BIT, r);
    r = 32'h1;
    while (r[0] !== 1'b0)
      ahb(1'b0, 32'(HOST_STAT_OFS), 32'h0, r);
    chk(32'(r[1]), 32'h1);
    chk(32'(ast), 32'h0);
    rd(2, 1, x);
    chk(32'(x), 32'h1FF);
    // Host restores every register after the train, then reads one back
    for (c = 0; c < 4; c++)
      for (k = 0; k < 3; k++)
        frame({5'(4 + 3 * c + k), 1'b1, 10'(rg[c][k])}, 1'b0, x);
    rd(3, 2, x);
    chk(32'(x), 32'(rg[3][2]));
    chk(32'(n_busy), 32'(78 * CONV_CYC));
    chk(32'(n_init), 32'h1);
    close_out();
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (80000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule
